// ---- bench/tsc_capability_map_tb.sv ----
// self-checking bench of the sensor register bank
// assumes: host model drives the access strobes, bench drives the rest
`timescale 1ns/1ns
`default_nettype none

module tsc_capability_map_tb;
  // arbitrary identity values
  localparam logic [15:0] MAKER = 16'h3C3C;
  localparam logic [15:0] PART  = 16'h0202;
  localparam logic [15:0] CAP   = {11'h000, 2'h2, 1'h1, 1'h0, 1'h1};

  logic        clk, rst, ce, temp_load;
  logic        ptr_wr, reg_wr, reg_rd, rd_valid, wr_ack, v, ack;
  logic [7:0]  ptr_wdata, pointer;
  logic [15:0] reg_wdata, temp_value, rd_data, d;
  logic [15:0] crit_trip_limit, bus_options;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;

  tsc_capability_map #(.MAKER_ID_VAL(MAKER), .PART_REV_VAL(PART)) dut (
    .clk(clk), .rst(rst), .ce(ce), .ptr_wr(ptr_wr),
    .ptr_wdata(ptr_wdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .temp_load(temp_load), .temp_value(temp_value),
    .pointer(pointer), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_ack(wr_ack), .crit_trip_limit(crit_trip_limit),
    .bus_options(bus_options));

  tsc_host_model host (
    .clk(clk), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_ack(wr_ack));

  // ==========================================================
  // checking
  task automatic chk(input string name, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    host.rd(a, d, v);
    chk("rd_valid", {15'h0000, v}, 16'h0001);
    chk("rd_data", d, exp);
  endtask

  task automatic wr_acked(input logic [7:0] a, input logic [15:0] w);
    host.wr(a, w, v);
    chk("wr_ack", {15'h0000, v}, 16'h0001);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("pointer", {8'h00, pointer}, 16'h0000);
    chk("crit_trip_limit", crit_trip_limit, 16'h0000);
    chk("bus_options", bus_options, 16'h0000);
    rd_chk(8'h04, 16'h0000);
    rd_chk(8'h22, 16'h0000);
  endtask

  task automatic t_capability();
    rd_chk(8'h00, CAP);
    wr_acked(8'h00, 16'hFFFF);
    rd_chk(8'h00, CAP);
  endtask

  task automatic t_identity();
    rd_chk(8'h06, MAKER);
    rd_chk(8'h07, PART);
    wr_acked(8'h06, ~MAKER);
    wr_acked(8'h07, ~PART);
    rd_chk(8'h06, MAKER);
    rd_chk(8'h07, PART);
  endtask

  task automatic t_writable();
    wr_acked(8'h04, 16'hA5C3);
    chk("pointer", {8'h00, pointer}, 16'h0004);
    chk("crit_trip_limit", crit_trip_limit, 16'hA5C3);
    wr_acked(8'h22, 16'h5A3C);
    chk("bus_options", bus_options, 16'h5A3C);
    chk("crit_trip_limit", crit_trip_limit, 16'hA5C3);
    rd_chk(8'h04, 16'hA5C3);
    rd_chk(8'h22, 16'h5A3C);
  endtask

  // with the enable low nothing may move, not even the pointer
  task automatic t_freeze();
    @(negedge clk);
    ce <= 1'h0;
    host.wr(8'h04, 16'h0F0F, v);
    chk("wr_ack", {15'h0000, v}, 16'h0000);
    chk("pointer", {8'h00, pointer}, 16'h0022);
    chk("crit_trip_limit", crit_trip_limit, 16'hA5C3);
    @(negedge clk);
    ce <= 1'h1;
  endtask

  // write then read at the next edge: the read must see the new word
  task automatic t_back_to_back();
    host.wr_rd(8'h04, 16'h3C5A, d, v, ack);
    chk("wr_ack", {15'h0000, ack}, 16'h0001);
    chk("rd_valid", {15'h0000, v}, 16'h0001);
    chk("rd_data", d, 16'h3C5A);
    chk("crit_trip_limit", crit_trip_limit, 16'h3C5A);
  endtask

  // negative result: sign bits must come back as loaded
  task automatic t_temperature();
    @(negedge clk);
    temp_load  <= 1'h1;
    temp_value <= 16'hFF38;
    @(negedge clk);
    temp_load  <= 1'h0;
    temp_value <= 16'h00C7;
    rd_chk(8'h05, 16'hFF38);
    wr_acked(8'h05, 16'h1234);
    rd_chk(8'h05, 16'hFF38);
  endtask

  task automatic t_reserved();
    logic [7:0] addrs [6] = '{8'h01, 8'h08, 8'h21, 8'h23, 8'h80, 8'hFF};
    foreach (addrs[i]) begin
      rd_chk(addrs[i], 16'h0000);
      chk("pointer", {8'h00, pointer}, {8'h00, addrs[i]});
    end
  endtask

  // ==========================================================
  // clock, timeout, main sequence
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    rst        = 1'h1;
    ce         = 1'h1;
    temp_load  = 1'h0;
    temp_value = 16'h0000;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_capability();
    t_identity();
    t_writable();
    t_freeze();
    t_back_to_back();
    t_temperature();
    t_reserved();
    print_verdict();
  end
endmodule

`default_nettype wire

// ---- bench/tsc_host_model.sv ----
// host-side model of the sensor bank: loads the pointer, moves words
// assumes: requests change at falling edges of the bank clock
`timescale 1ns/1ns
`default_nettype none

module tsc_host_model (
  // clock
  input  wire logic        clk,
  // requests
  output var  logic        ptr_wr,
  output var  logic [7:0]  ptr_wdata,
  output var  logic        reg_wr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_rd,
  // answers
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        wr_ack
);
  // ==========================================================
  // idle lines
  initial begin
    ptr_wr    = 1'h0;
    ptr_wdata = 8'h00;
    reg_wr    = 1'h0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'h0;
  end

  // ==========================================================
  // transfers
  // released data lines show the inverse, so stale values never match
  task automatic set_ptr(input logic [7:0] a);
    @(negedge clk);
    ptr_wr    <= 1'h1;
    ptr_wdata <= a;
    @(negedge clk);
    ptr_wr    <= 1'h0;
    ptr_wdata <= ~a;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    set_ptr(a);
    reg_rd <= 1'h1;
    @(negedge clk);
    reg_rd <= 1'h0;
    d = rd_data;
    v = rd_valid;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    output logic ack);
    ack = 1'h0;
    // reserved places 08h-21h and 23h-FFh are never written: no way back without power
    if (a inside {[8'h08:8'h21], [8'h23:8'hFF]})
      return;
    set_ptr(a);
    reg_wr    <= 1'h1;
    reg_wdata <= d;
    @(negedge clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~d;
    ack = wr_ack;
  endtask

  // write, then read the same place at the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] w,
                       output logic [15:0] d, output logic v,
                       output logic ack);
    ack = 1'h0;
    d   = 16'h0000;
    v   = 1'h0;
    if (a inside {[8'h08:8'h21], [8'h23:8'hFF]})
      return;
    set_ptr(a);
    reg_wr    <= 1'h1;
    reg_wdata <= w;
    @(negedge clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~w;
    reg_rd    <= 1'h1;
    ack = wr_ack;
    @(negedge clk);
    reg_rd <= 1'h0;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule

`default_nettype wire

// ---- rtl/tsc_capability_map.sv ----
// register bank of the memory-module temperature sensor
// assumes: the serial engine decodes frames and hands over pointer
// and data strobes in the clk domain; the converter loads results there
//
// Behaviour
// - a read-only capability word sits at 00h and writes never change it.
// - capability bits 15 to 5 always read zero.
// - capability bits 4:3 read 10b: 0.125 degC per lsb over 11 bits.
// - capability bit 2 reads one: negative temperatures are reported.
// - capability bit 1 reads zero, the standard accuracy grade.
// - capability bit 0 reads one, showing window and critical alarm support.
// - critical trip limit at 04h resets to 0000h; temperature sits at 05h.
// - the bus option register sits at 22h and resets to 0000h.
// - fixed maker and part/revision words at 06h and 07h ignore writes.
// - an 8-bit pointer selects the register; all others are 16 bits.
// - a write to a read-only register is acknowledged, its data dropped.
`timescale 1ns/1ns
`default_nettype none

module tsc_capability_map #(
  // arbitrary neutral identity values
  parameter logic [15:0] MAKER_ID_VAL = 16'h5A5A,
  parameter logic [15:0] PART_REV_VAL = 16'h0101
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // pointer load from the serial engine
  input  wire logic        ptr_wr,
  input  wire logic [7:0]  ptr_wdata,
  // register access at the current pointer
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  // result from the conversion engine
  input  wire logic        temp_load,
  input  wire logic [15:0] temp_value,
  // answers
  output var  logic [7:0]  pointer,
  output var  logic [15:0] rd_data,
  output var  logic        rd_valid,
  output var  logic        wr_ack,
  // held settings for the alarm and bus logic
  output var  logic [15:0] crit_trip_limit,
  output var  logic [15:0] bus_options
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // state
  tsc_pkg::tsc_state_t st_q;
  tsc_pkg::tsc_state_t st_d;

  logic        crit_we;
  logic        bus_we;
  logic [15:0] crit_q;
  logic [15:0] bus_q;
  logic [15:0] read_mux;

  // ==========================================================
  // writable registers
  // only the two mapped read/write addresses decode a write strobe;
  // reserved and read-only addresses fall through and drop the data
  always_comb begin
    crit_we = reg_wr && (st_q.ptr == tsc_pkg::ADDR_CRIT_TRIP);
    bus_we  = reg_wr && (st_q.ptr == tsc_pkg::ADDR_BUS_OPTIONS);
  end

  tsc_hold_reg #(
    .RESET_VAL (tsc_pkg::CRIT_TRIP_RESET)
  ) u_crit (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .we  (crit_we),
    .d   (reg_wdata),
    .q   (crit_q)
  );

  tsc_hold_reg #(
    .RESET_VAL (tsc_pkg::BUS_OPTIONS_RESET)
  ) u_bus (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .we  (bus_we),
    .d   (reg_wdata),
    .q   (bus_q)
  );

  // ==========================================================
  // read selection
  always_comb begin
    unique case (st_q.ptr)
      tsc_pkg::ADDR_CAPABILITY: begin
        read_mux = tsc_pkg::CAPABILITY_WORD;
      end
      tsc_pkg::ADDR_CRIT_TRIP: begin
        read_mux = crit_q;
      end
      tsc_pkg::ADDR_TEMPERATURE: begin
        read_mux = st_q.temp;
      end
      tsc_pkg::ADDR_MAKER_ID: begin
        read_mux = MAKER_ID_VAL;
      end
      tsc_pkg::ADDR_PART_REV: begin
        read_mux = PART_REV_VAL;
      end
      tsc_pkg::ADDR_BUS_OPTIONS: begin
        read_mux = bus_q;
      end
      default: begin
        read_mux = tsc_pkg::RESERVED_READ_VAL;
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;
    st_d.wr_ack   = 1'b0;
    if (ptr_wr) begin
      st_d.ptr = ptr_wdata;
    end
    // every data write is acknowledged, mapped or not
    if (reg_wr) begin
      st_d.wr_ack = 1'b1;
    end
    // a read sees the pointer and contents of before this edge
    if (reg_rd) begin
      st_d.rd_data  = read_mux;
      st_d.rd_valid = 1'b1;
    end
    // the measured value is loaded only by the converter, never by the bus
    if (temp_load) begin
      st_d.temp = temp_value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q.ptr      <= tsc_pkg::POINTER_RESET;
      st_q.temp     <= tsc_pkg::TEMPERATURE_RESET;
      st_q.rd_data  <= 16'h0000;
      st_q.rd_valid <= 1'b0;
      st_q.wr_ack   <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign pointer         = st_q.ptr;
  assign rd_data         = st_q.rd_data;
  assign rd_valid        = st_q.rd_valid;
  assign wr_ack          = st_q.wr_ack;
  assign crit_trip_limit = crit_q;
  assign bus_options     = bus_q;

  // ==========================================================
  // checks

  sequence s_read_at(logic [7:0] addr);
    ce && reg_rd && (st_q.ptr == addr);
  endsequence

  sequence s_write_at(logic [7:0] addr);
    ce && reg_wr && (st_q.ptr == addr);
  endsequence

  property p_cap_word;
    s_read_at(8'h00) |=> rd_valid && (rd_data == 16'h0015);
  endproperty
  a_cap_word: assert property (p_cap_word)
    else $error("capability word read wrong");

  property p_cap_spare;
    s_read_at(8'h00) |=> (rd_data[15:5] == 11'h000);
  endproperty
  a_cap_spare: assert property (p_cap_spare)
    else $error("capability spare bits not zero");

  property p_cap_res;
    s_read_at(8'h00) |=> (rd_data[4:3] == 2'h2);
  endproperty
  a_cap_res: assert property (p_cap_res)
    else $error("resolution code wrong");

  property p_cap_flags;
    s_read_at(8'h00) |=> rd_data[2] && !rd_data[1] && rd_data[0];
  endproperty
  a_cap_flags: assert property (p_cap_flags)
    else $error("capability flags wrong");

  property p_crit_write;
    s_write_at(8'h04) ##1 ce && reg_rd && (st_q.ptr == 8'h04)
      |=> (rd_data == $past(reg_wdata, 2));
  endproperty
  a_crit_write: assert property (p_crit_write)
    else $error("critical limit not written");

  property p_bus_write;
    s_write_at(8'h22) |=> (bus_options == $past(reg_wdata));
  endproperty
  a_bus_write: assert property (p_bus_write)
    else $error("bus options not written");

  property p_id_read;
    s_read_at(8'h06) |=> (rd_data == MAKER_ID_VAL);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("maker identity word wrong");

  property p_rev_read;
    s_read_at(8'h07) |=> (rd_data == PART_REV_VAL);
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("part identity word wrong");

  property p_ptr_load;
    ce && ptr_wr |=> (pointer == $past(ptr_wdata));
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded");

  property p_ro_drop;
    ce && reg_wr && (st_q.ptr != 8'h04) && (st_q.ptr != 8'h22)
      |=> wr_ack && $stable(crit_trip_limit) && $stable(bus_options);
  endproperty
  a_ro_drop: assert property (p_ro_drop)
    else $error("read-only write not dropped or not acked");

  property p_reserved_zero;
    ce && reg_rd && (st_q.ptr > 8'h07) && (st_q.ptr != 8'h22)
      |=> rd_valid && (rd_data == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved address read not zero");

endmodule

`default_nettype wire

// ---- rtl/tsc_hold_reg.sv ----
// one writable 16-bit register with a constant reset value
// assumes: write strobe already decoded by the caller, same clock
`timescale 1ns/1ns
`default_nettype none

module tsc_hold_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // write side
  input  wire logic        we,
  input  wire logic [15:0] d,
  // held value
  output var  logic [15:0] q
);

  logic [15:0] q_q;
  logic [15:0] q_d;

  always_comb begin
    q_d = q_q;
    if (ce && we) begin
      q_d = d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_q <= RESET_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule

`default_nettype wire

// ---- rtl/tsc_pkg.sv ----
// register map, capability fields and reset values of the sensor bank
// assumes: single clock domain, pointer-indexed 16-bit registers
package tsc_pkg;

  // ==========================================================
  // widths
  localparam int PTR_W = 8;
  localparam int REG_W = 16;

  // ==========================================================
  // pointer addresses
  localparam logic [7:0] ADDR_CAPABILITY  = 8'h00;
  localparam logic [7:0] ADDR_CRIT_TRIP   = 8'h04;
  localparam logic [7:0] ADDR_TEMPERATURE = 8'h05;
  localparam logic [7:0] ADDR_MAKER_ID    = 8'h06;
  localparam logic [7:0] ADDR_PART_REV    = 8'h07;
  localparam logic [7:0] ADDR_BUS_OPTIONS = 8'h22;

  // ==========================================================
  // capability word fields
  localparam int SPARE_BITS_LSB          = 5;
  localparam int RESOLUTION_CODE_LSB     = 3;
  localparam int NEGATIVE_RANGE_FLAG_BIT = 2;
  localparam int ACCURACY_GRADE_FLAG_BIT = 1;
  localparam int ALARM_SUPPORT_FLAG_BIT  = 0;

  localparam logic [10:0] SPARE_BITS_VAL          = 11'h000;
  // 0.125 degC per lsb, 11-bit result
  localparam logic [1:0]  RESOLUTION_CODE_VAL     = 2'h2;
  localparam logic        NEGATIVE_RANGE_FLAG_VAL = 1'h1;
  // standard grade accuracy, fixed at manufacture
  localparam logic        ACCURACY_GRADE_FLAG_VAL = 1'h0;
  localparam logic        ALARM_SUPPORT_FLAG_VAL  = 1'h1;

  localparam logic [15:0] CAPABILITY_WORD = {
    SPARE_BITS_VAL, RESOLUTION_CODE_VAL, NEGATIVE_RANGE_FLAG_VAL,
    ACCURACY_GRADE_FLAG_VAL, ALARM_SUPPORT_FLAG_VAL};

  // ==========================================================
  // reset values
  localparam logic [15:0] CRIT_TRIP_RESET   = 16'h0000;
  localparam logic [15:0] BUS_OPTIONS_RESET = 16'h0000;
  localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
  localparam logic [15:0] RESERVED_READ_VAL = 16'h0000;
  localparam logic [7:0]  POINTER_RESET     = 8'h00;

  // ==========================================================
  // state of the bank
  typedef struct packed {
    logic [7:0]  ptr;
    logic [15:0] temp;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        wr_ack;
  } tsc_state_t;

endpackage
